/* cwgsl_top.sv */
// Shutdown level and source selection for a complementary waveform
// generator, with its 8-bit configuration register on AXI4-Lite.
// Assumes shutdown, polarity and dead-band length come from sibling
// logic, all synchronous to CORE_CLK_I.
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps

// How it works
// [R01] Shutdown levels act only while the shutdown flag is high.
// [R02] Output B level code 11 drives B high, polarity ignored.
// [R03] Output B level code 10 drives B low, polarity ignored.
// [R04] Output B level code 01 releases B to high impedance.
// [R05] Output B code 00 goes idle after the dead-band, polarity kept.
// [R06] Output A level code 11 drives A high, polarity ignored.
// [R07] Output A level code 10 drives A low, polarity ignored.
// [R08] Output A level code 01 releases A to high impedance.
// [R09] Output A code 00 goes idle after the dead-band, polarity kept.
// [R10] Configuration bit 3 always reads zero and ignores writes.
// [R11] Source code 110 picks the input pin; 111 is reserved.
// [R12] Source code 101 picks modulator 4, 100 picks modulator 3.
// [R13] Codes 011 and 010 pick modulators 2 and 1; others reserved.
// [R14] Each output follows only its own two-bit shutdown field.
module cwgsl_top
(
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RESET_I,
    // AXI4-Lite write address
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_AWADDR_I,
    // AXI4-Lite write data
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    // AXI4-Lite write response
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    output logic [1:0] S_AXI_BRESP_O,
    // AXI4-Lite read address
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    input wire logic [31:0] S_AXI_ARADDR_I,
    // AXI4-Lite read data
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    // Shutdown, polarity and dead-band from sibling logic
    input wire logic SHUTDOWN_ACTIVE_FLAG_I,
    input wire logic OUT_A_POLARITY_I,
    input wire logic OUT_B_POLARITY_I,
    input wire logic [cwgsl_pkg::DB_W-1:0] DEADBAND_CYCLES_I,
    // Waveform sources
    input wire logic MODULATOR1_OUTPUT_I,
    input wire logic MODULATOR2_OUTPUT_I,
    input wire logic MODULATOR3_OUTPUT_I,
    input wire logic MODULATOR4_OUTPUT_I,
    input wire logic GEN_INPUT_PIN_I,
    // Complementary output pins
    output logic COMPLEMENTARY_OUT_A_O,
    output logic COMPLEMENTARY_OUT_A_OE_O,
    output logic COMPLEMENTARY_OUT_B_O,
    output logic COMPLEMENTARY_OUT_B_OE_O
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed
    {
        logic [7:0] cfg;
        logic [31:0] awaddr;
        logic aw_got;
        logic [7:0] wbyte;
        logic wstrb0;
        logic w_got;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } cwgsl_top_st_t;

    cwgsl_top_st_t r_ff;
    cwgsl_top_st_t nxt_r;

    logic src;
    logic norm_a;
    logic norm_b;
    logic [1:0] lvl_a;
    logic [1:0] lvl_b;
    logic [7:0] stat;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;

    // Address decode shared by the read and write paths
    // Returns 2'b01 for configuration, 2'b10 for status, 0 unmapped
    function automatic logic [1:0] dec_addr(input logic [31:0] a);
        logic [1:0] hit;
        hit = 2'b00;
        if (a[31:2] == cwgsl_pkg::ADDR_CFG[31:2])
            hit = 2'b01;
        else if (a[31:2] == cwgsl_pkg::ADDR_STAT[31:2])
            hit = 2'b10;
        return hit;
    endfunction

    // ----------------------------------------------------------------
    // Bus handshakes
    // ----------------------------------------------------------------
    // Address and data are caught separately, in either order; both
    // stall while a response waits so only one write is in flight
    assign S_AXI_AWREADY_O = !r_ff.aw_got && !r_ff.bvalid;
    assign S_AXI_WREADY_O = !r_ff.w_got && !r_ff.bvalid;
    assign S_AXI_ARREADY_O = !r_ff.rvalid;
    assign aw_hs = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
    assign w_hs = S_AXI_WVALID_I && S_AXI_WREADY_O;
    assign ar_hs = S_AXI_ARVALID_I && S_AXI_ARREADY_O;

    // Status word: live view of the block's own state
    always_comb
    begin
        stat = 8'h00;
        stat[cwgsl_pkg::STAT_SD] = SHUTDOWN_ACTIVE_FLAG_I;
        stat[cwgsl_pkg::STAT_SRC] = src;
        stat[cwgsl_pkg::STAT_OUTA] = COMPLEMENTARY_OUT_A_O;
        stat[cwgsl_pkg::STAT_OEA] = COMPLEMENTARY_OUT_A_OE_O;
        stat[cwgsl_pkg::STAT_OUTB] = COMPLEMENTARY_OUT_B_O;
        stat[cwgsl_pkg::STAT_OEB] = COMPLEMENTARY_OUT_B_OE_O;
    end

    // ----------------------------------------------------------------
    // Register slave
    // ----------------------------------------------------------------
    // Write commits the cycle after both halves are held, response
    // rises on that same edge; read data is answered one edge after AR
    always_comb
    begin
        nxt_r = r_ff;
        if (aw_hs)
        begin
            nxt_r.aw_got = 1'b1;
            nxt_r.awaddr = S_AXI_AWADDR_I;
        end
        if (w_hs)
        begin
            nxt_r.w_got = 1'b1;
            nxt_r.wbyte = S_AXI_WDATA_I[7:0];
            nxt_r.wstrb0 = S_AXI_WSTRB_I[0];
        end
        if (r_ff.aw_got && r_ff.w_got && !r_ff.bvalid)
        begin
            nxt_r.aw_got = 1'b0;
            nxt_r.w_got = 1'b0;
            nxt_r.bvalid = 1'b1;
            nxt_r.bresp = cwgsl_pkg::RESP_OKAY;
            if (dec_addr(r_ff.awaddr) == 2'b01)
            begin
                if (r_ff.wstrb0)
                    nxt_r.cfg = r_ff.wbyte & cwgsl_pkg::CFG_WMASK; // [R10]
            end
            else if (dec_addr(r_ff.awaddr) == 2'b10)
                nxt_r.bresp = cwgsl_pkg::RESP_OKAY;
            else
                nxt_r.bresp = cwgsl_pkg::RESP_SLVERR;
        end
        else if (r_ff.bvalid && S_AXI_BREADY_I)
            nxt_r.bvalid = 1'b0;
        if (ar_hs)
        begin
            nxt_r.rvalid = 1'b1;
            nxt_r.rresp = cwgsl_pkg::RESP_OKAY;
            nxt_r.rdata = 32'h0000_0000;
            if (dec_addr(S_AXI_ARADDR_I) == 2'b01)
                nxt_r.rdata[7:0] = r_ff.cfg; // [R10]
            else if (dec_addr(S_AXI_ARADDR_I) == 2'b10)
                nxt_r.rdata[7:0] = stat;
            else
                nxt_r.rresp = cwgsl_pkg::RESP_SLVERR;
        end
        else if (r_ff.rvalid && S_AXI_RREADY_I)
            nxt_r.rvalid = 1'b0;
    end

    // State register
    always_ff @(posedge CORE_CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            r_ff <= '0;
            r_ff.cfg <= cwgsl_pkg::CFG_RESET;
        end
        else
            r_ff <= nxt_r;
    end

    assign S_AXI_BVALID_O = r_ff.bvalid;
    assign S_AXI_BRESP_O = r_ff.bresp;
    assign S_AXI_RVALID_O = r_ff.rvalid;
    assign S_AXI_RDATA_O = r_ff.rdata;
    assign S_AXI_RRESP_O = r_ff.rresp;

    // ----------------------------------------------------------------
    // Waveform path
    // ----------------------------------------------------------------
    // B is the complement of A before polarity is applied
    assign norm_a = src ^ OUT_A_POLARITY_I;
    assign norm_b = ~src ^ OUT_B_POLARITY_I;
    // Each stage sees only its own field, so A and B never interact
    assign lvl_a = r_ff.cfg[cwgsl_pkg::CFG_LVLA_LSB +: 2]; // [R14]
    assign lvl_b = r_ff.cfg[cwgsl_pkg::CFG_LVLB_LSB +: 2]; // [R14]

    cwgsl_src_mux u_src
    (
        .clk_i(CORE_CLK_I),
        .rst_i(RESET_I),
        .sel_i(r_ff.cfg[cwgsl_pkg::CFG_SRC_LSB +: 3]),
        .mod1_i(MODULATOR1_OUTPUT_I),
        .mod2_i(MODULATOR2_OUTPUT_I),
        .mod3_i(MODULATOR3_OUTPUT_I),
        .mod4_i(MODULATOR4_OUTPUT_I),
        .pin_i(GEN_INPUT_PIN_I),
        .src_o(src)
    );

    cwgsl_out_stage u_out_a
    (
        .clk_i(CORE_CLK_I),
        .rst_i(RESET_I),
        .sd_i(SHUTDOWN_ACTIVE_FLAG_I),
        .lvl_i(lvl_a),
        .pol_i(OUT_A_POLARITY_I),
        .db_i(DEADBAND_CYCLES_I),
        .norm_i(norm_a),
        .out_o(COMPLEMENTARY_OUT_A_O),
        .oe_o(COMPLEMENTARY_OUT_A_OE_O)
    );

    cwgsl_out_stage u_out_b
    (
        .clk_i(CORE_CLK_I),
        .rst_i(RESET_I),
        .sd_i(SHUTDOWN_ACTIVE_FLAG_I),
        .lvl_i(lvl_b),
        .pol_i(OUT_B_POLARITY_I),
        .db_i(DEADBAND_CYCLES_I),
        .norm_i(norm_b),
        .out_o(COMPLEMENTARY_OUT_B_O),
        .oe_o(COMPLEMENTARY_OUT_B_OE_O)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_bit3_zero;
        @(posedge CORE_CLK_I) disable iff (RESET_I)
        S_AXI_RVALID_O && $past(ar_hs) &&
        dec_addr($past(S_AXI_ARADDR_I)) == 2'b01 |-> !S_AXI_RDATA_O[3];
    endproperty
    a_bit3_zero: assert property (p_bit3_zero) // [R10]
        else $error("configuration bit 3 read back as one");

    property p_indep;
        @(posedge CORE_CLK_I) disable iff (RESET_I)
        SHUTDOWN_ACTIVE_FLAG_I && lvl_a == cwgsl_pkg::LVL_LOW &&
        lvl_b == cwgsl_pkg::LVL_TRI
        |=> !COMPLEMENTARY_OUT_A_O && COMPLEMENTARY_OUT_A_OE_O &&
        !COMPLEMENTARY_OUT_B_OE_O;
    endproperty
    a_indep: assert property (p_indep) // [R14]
        else $error("output levels not applied independently");

    property p_wr_resp;
        @(posedge CORE_CLK_I) disable iff (RESET_I)
        r_ff.aw_got && r_ff.w_got && !r_ff.bvalid |=> S_AXI_BVALID_O;
    endproperty
    a_wr_resp: assert property (p_wr_resp)
        else $error("write response missing");

    property p_rd_resp;
        @(posedge CORE_CLK_I) disable iff (RESET_I)
        ar_hs |=> S_AXI_RVALID_O;
    endproperty
    a_rd_resp: assert property (p_rd_resp)
        else $error("read data missing");

    // A pending response must block both write channels
    property p_one_write;
        @(posedge CORE_CLK_I) disable iff (RESET_I)
        S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O;
    endproperty
    a_one_write: assert property (p_one_write)
        else $error("write taken while a response waits");

    property p_cfg_hold;
        @(posedge CORE_CLK_I) disable iff (RESET_I)
        !(r_ff.aw_got && r_ff.w_got) |=> $stable(r_ff.cfg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("configuration changed without a write");

    c_cfg_wr: cover property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        S_AXI_BVALID_O && S_AXI_BREADY_I);
    c_cfg_rd: cover property (@(posedge CORE_CLK_I) disable iff (RESET_I)
        S_AXI_RVALID_O && S_AXI_RREADY_I);

endmodule // cwgsl_top

/* cwgsl_pkg.sv */
// Constants shared by the shutdown-level and source-select block.
// Assumes a 32-bit AXI4-Lite register bus and one 100 MHz core clock.
package cwgsl_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [31:0] ADDR_CFG = 32'h0000_0000;
    localparam logic [31:0] ADDR_STAT = 32'h0000_0004;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // Bit 3 is not implemented and is dropped on every write
    localparam logic [7:0] CFG_WMASK = 8'hF7;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CFG_LVLB_LSB = 6;
    localparam int CFG_LVLA_LSB = 4;
    localparam int CFG_SRC_LSB = 0;
    localparam int STAT_SD = 0;
    localparam int STAT_SRC = 1;
    localparam int STAT_OUTA = 2;
    localparam int STAT_OEA = 3;
    localparam int STAT_OUTB = 4;
    localparam int STAT_OEB = 5;

    // ----------------------------------------------------------------
    // Encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] LVL_DB = 2'h0;
    localparam logic [1:0] LVL_TRI = 2'h1;
    localparam logic [1:0] LVL_LOW = 2'h2;
    localparam logic [1:0] LVL_HIGH = 2'h3;
    localparam logic [2:0] SRC_M1 = 3'h2;
    localparam logic [2:0] SRC_M2 = 3'h3;
    localparam logic [2:0] SRC_M3 = 3'h4;
    localparam logic [2:0] SRC_M4 = 3'h5;
    localparam logic [2:0] SRC_PIN = 3'h6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Dead-band counter width
    // ----------------------------------------------------------------
    localparam int DB_W = 6;

    // Shutdown sequencing states of one output
    typedef enum logic [2:0]
    {
        ST_RUN = 3'b001,
        ST_WAIT = 3'b010,
        ST_HOLD = 3'b100
    } cwgsl_sd_state_t;

endpackage

/* cwgsl_src_mux.sv */
// Waveform source selector: one of four modulators or the input pin.
// Assumes all sources are synchronous to the core clock.
`timescale 1ns/1ps
module cwgsl_src_mux
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Selection and sources
    input wire logic [2:0] sel_i,
    input wire logic mod1_i,
    input wire logic mod2_i,
    input wire logic mod3_i,
    input wire logic mod4_i,
    input wire logic pin_i,
    // Selected source, registered
    output logic src_o
);

    typedef struct packed
    {
        logic src;
    } cwgsl_mux_st_t;

    cwgsl_mux_st_t r_ff;
    cwgsl_mux_st_t nxt_r;

    // ----------------------------------------------------------------
    // Selection
    // ----------------------------------------------------------------
    // Reserved codes give a steady low so the generator sees no edges
    always_comb
    begin
        nxt_r = r_ff;
        case (sel_i)
            cwgsl_pkg::SRC_PIN: nxt_r.src = pin_i; // [R11]
            cwgsl_pkg::SRC_M4: nxt_r.src = mod4_i; // [R12]
            cwgsl_pkg::SRC_M3: nxt_r.src = mod3_i; // [R12]
            cwgsl_pkg::SRC_M2: nxt_r.src = mod2_i; // [R13]
            cwgsl_pkg::SRC_M1: nxt_r.src = mod1_i; // [R13]
            default: nxt_r.src = 1'b0; // [R11] [R13]
        endcase
    end

    // State register
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            r_ff <= '0;
        else
            r_ff <= nxt_r;
    end

    assign src_o = r_ff.src;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_sel_pin;
        @(posedge clk_i) disable iff (rst_i)
        sel_i == cwgsl_pkg::SRC_PIN |=> src_o == $past(pin_i);
    endproperty
    a_sel_pin: assert property (p_sel_pin) // [R11]
        else $error("pin source not routed");

    property p_sel_mod;
        @(posedge clk_i) disable iff (rst_i)
        (sel_i == cwgsl_pkg::SRC_M4 && mod4_i) ||
        (sel_i == cwgsl_pkg::SRC_M3 && mod3_i) |=> src_o;
    endproperty
    a_sel_mod: assert property (p_sel_mod) // [R12]
        else $error("modulator 4 or 3 not routed");

    property p_sel_rsv;
        @(posedge clk_i) disable iff (rst_i)
        (sel_i == 3'h7 || sel_i == 3'h1 || sel_i == 3'h0) |=> !src_o;
    endproperty
    a_sel_rsv: assert property (p_sel_rsv) // [R13]
        else $error("reserved source code produced a level");

    c_sel_pin: cover property (@(posedge clk_i) disable iff (rst_i)
        sel_i == cwgsl_pkg::SRC_PIN ##1 src_o);

endmodule // cwgsl_src_mux

/* cwgsl_out_stage.sv */
// One complementary output with its auto-shutdown level handling.
// Assumes the normal waveform arrives with polarity already applied.
`timescale 1ns/1ps
module cwgsl_out_stage
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic sd_i,
    input wire logic [1:0] lvl_i,
    input wire logic pol_i,
    input wire logic [cwgsl_pkg::DB_W-1:0] db_i,
    input wire logic norm_i,
    // Pin drive
    output logic out_o,
    output logic oe_o
);

    typedef struct packed
    {
        cwgsl_pkg::cwgsl_sd_state_t state;
        logic [cwgsl_pkg::DB_W-1:0] cnt;
        logic out;
        logic oe;
    } cwgsl_stage_st_t;

    cwgsl_stage_st_t r_ff;
    cwgsl_stage_st_t nxt_r;

    // ----------------------------------------------------------------
    // Shutdown sequencing
    // ----------------------------------------------------------------
    // Fixed levels act at once; the dead-band choice holds the last
    // level for db_i+1 cycles, then parks at the polarity's idle level
    always_comb
    begin
        nxt_r = r_ff;
        if (!sd_i)
        begin
            nxt_r.state = cwgsl_pkg::ST_RUN; // [R01]
            nxt_r.cnt = '0;
            nxt_r.out = norm_i;
            nxt_r.oe = 1'b1;
        end
        else
        begin
            case (lvl_i)
                cwgsl_pkg::LVL_HIGH:
                begin
                    nxt_r.state = cwgsl_pkg::ST_RUN;
                    nxt_r.out = 1'b1; // [R02] [R06]
                    nxt_r.oe = 1'b1;
                end
                cwgsl_pkg::LVL_LOW:
                begin
                    nxt_r.state = cwgsl_pkg::ST_RUN;
                    nxt_r.out = 1'b0; // [R03] [R07]
                    nxt_r.oe = 1'b1;
                end
                cwgsl_pkg::LVL_TRI:
                begin
                    nxt_r.state = cwgsl_pkg::ST_RUN;
                    nxt_r.out = 1'b0;
                    nxt_r.oe = 1'b0; // [R04] [R08]
                end
                default:
                begin
                    nxt_r.oe = 1'b1;
                    case (r_ff.state)
                        cwgsl_pkg::ST_RUN:
                        begin
                            nxt_r.state = cwgsl_pkg::ST_WAIT; // [R05] [R09]
                            nxt_r.cnt = db_i;
                        end
                        cwgsl_pkg::ST_WAIT:
                        begin
                            if (r_ff.cnt == '0)
                            begin
                                nxt_r.state = cwgsl_pkg::ST_HOLD;
                                nxt_r.out = pol_i; // [R05] [R09]
                            end
                            else
                                nxt_r.cnt = r_ff.cnt - 1'b1;
                        end
                        default:
                            nxt_r.out = pol_i; // [R05] [R09]
                    endcase
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            r_ff <= '{state: cwgsl_pkg::ST_RUN, cnt: '0, out: 1'b0, oe: 1'b1};
        else
            r_ff <= nxt_r;
    end

    assign out_o = r_ff.out;
    assign oe_o = r_ff.oe;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_normal;
        @(posedge clk_i) disable iff (rst_i)
        !sd_i |=> oe_o && out_o == $past(norm_i);
    endproperty
    a_normal: assert property (p_normal) // [R01]
        else $error("output not following waveform outside shutdown");

    property p_high;
        @(posedge clk_i) disable iff (rst_i)
        sd_i && lvl_i == cwgsl_pkg::LVL_HIGH |=> out_o && oe_o;
    endproperty
    a_high: assert property (p_high) // [R02] [R06]
        else $error("shutdown high level not driven");

    property p_low;
        @(posedge clk_i) disable iff (rst_i)
        sd_i && lvl_i == cwgsl_pkg::LVL_LOW |=> !out_o && oe_o;
    endproperty
    a_low: assert property (p_low) // [R03] [R07]
        else $error("shutdown low level not driven");

    property p_tri;
        @(posedge clk_i) disable iff (rst_i)
        sd_i && lvl_i == cwgsl_pkg::LVL_TRI |=> !oe_o;
    endproperty
    a_tri: assert property (p_tri) // [R04] [R08]
        else $error("shutdown tri-state not applied");

    property p_db_wait;
        @(posedge clk_i) disable iff (rst_i)
        sd_i && lvl_i == cwgsl_pkg::LVL_DB &&
        r_ff.state == cwgsl_pkg::ST_WAIT && r_ff.cnt != '0
        |=> $stable(out_o) && oe_o;
    endproperty
    a_db_wait: assert property (p_db_wait) // [R05] [R09]
        else $error("output moved before dead-band ended");

    property p_db_idle;
        @(posedge clk_i) disable iff (rst_i)
        sd_i && lvl_i == cwgsl_pkg::LVL_DB &&
        r_ff.state == cwgsl_pkg::ST_WAIT && r_ff.cnt == '0
        |=> out_o == $past(pol_i) && r_ff.state == cwgsl_pkg::ST_HOLD;
    endproperty
    a_db_idle: assert property (p_db_idle) // [R05] [R09]
        else $error("idle level not reached after dead-band");

    c_db_hold: cover property (@(posedge clk_i) disable iff (rst_i)
        r_ff.state == cwgsl_pkg::ST_WAIT ##1
        r_ff.state == cwgsl_pkg::ST_HOLD);
    c_tri: cover property (@(posedge clk_i) disable iff (rst_i)
        oe_o ##1 !oe_o);

endmodule // cwgsl_out_stage

/* cwgsl_pins.sv */
// Power stage pins seen by the two complementary outputs.
// Assumes a pin with no pull resistor, so a released pin floats.
`timescale 1ns/1ps
module cwgsl_pins
(
    // Clock
    input wire logic clk_i,
    // Drive from the block
    input wire logic a_i,
    input wire logic a_oe_i,
    input wire logic b_i,
    input wire logic b_oe_i,
    // Pin levels
    output logic a_pin_o,
    output logic b_pin_o
);
    logic last_a;
    logic last_b;
    // Remember the last driven level of each pin
    always_ff @(posedge clk_i)
    begin
        if (a_oe_i) last_a <= a_i;
        if (b_oe_i) last_b <= b_i;
    end
    // A floating pin shows the inverse, so a stale value never matches
    assign a_pin_o = a_oe_i ? a_i : ~last_a;
    assign b_pin_o = b_oe_i ? b_i : ~last_b;
endmodule // cwgsl_pins

/* cwg_shutdown_level_and_source_select_tb_top.sv */
// Self-checking bench: register access over AXI4-Lite, source selection
// and shutdown levels. Assumes the register map of the shared package.
`timescale 1ns/1ps
module cwg_shutdown_level_and_source_select_tb_top;
    logic clk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic [31:0] awa = 0, wd = 0, ara = 0, rd;
    logic [3:0] ws = 4'hF;
    logic awr, wr, bv, arr, rv, oa, oea, ob, oeb, pina, pinb;
    logic [1:0] bresp, rresp;
    logic sd = 0, pa = 1, pb = 0;
    logic [5:0] db = 6'h03;
    logic [4:0] v = 5'h00;
    int errors = 0, n_tests = 0;
    always #5 clk = ~clk;
    cwgsl_top uut (.CORE_CLK_I(clk), .RESET_I(rst),
        .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_AWADDR_I(awa),
        .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr), .S_AXI_WDATA_I(wd),
        .S_AXI_WSTRB_I(ws), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br),
        .S_AXI_BRESP_O(bresp), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
        .S_AXI_ARADDR_I(ara), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr),
        .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rresp),
        .SHUTDOWN_ACTIVE_FLAG_I(sd), .OUT_A_POLARITY_I(pa),
        .OUT_B_POLARITY_I(pb), .DEADBAND_CYCLES_I(db),
        .MODULATOR1_OUTPUT_I(v[0]), .MODULATOR2_OUTPUT_I(v[1]),
        .MODULATOR3_OUTPUT_I(v[2]), .MODULATOR4_OUTPUT_I(v[3]),
        .GEN_INPUT_PIN_I(v[4]), .COMPLEMENTARY_OUT_A_O(oa),
        .COMPLEMENTARY_OUT_A_OE_O(oea), .COMPLEMENTARY_OUT_B_O(ob),
        .COMPLEMENTARY_OUT_B_OE_O(oeb));
    cwgsl_pins pins (.clk_i(clk), .a_i(oa), .a_oe_i(oea), .b_i(ob),
        .b_oe_i(oeb), .a_pin_o(pina), .b_pin_o(pinb));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic give_verdict;
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tmo;
        errors++;
        $display("Error at %0t: handshake wait ran out", $time);
        give_verdict();
    endtask
    // Ready is looked at between edges, so a handshake is never missed
    task automatic axw(input logic [31:0] a, d, output logic [1:0] r);
        logic ta, tw, tb;
        tb = 0;
        @(posedge clk);
        awv <= 1; wv <= 1; awa <= a; wd <= d; br <= 1;
        for (int i = 0; i < 50 && !tb; i++)
        begin
            #1 ta = awv && awr; tw = wv && wr; tb = bv; r = bresp;
            @(posedge clk);
            if (ta) awv <= 0;
            if (tw) wv <= 0;
            if (tb) br <= 0;
        end
        if (!tb) tmo();
    endtask
    task automatic axr(input logic [31:0] a, output logic [31:0] d,
        output logic [1:0] r);
        logic ta, tr;
        tr = 0;
        @(posedge clk);
        arv <= 1; ara <= a; rr <= 1;
        for (int i = 0; i < 50 && !tr; i++)
        begin
            #1 ta = arv && arr; tr = rv; d = rd; r = rresp;
            @(posedge clk);
            if (ta) arv <= 0;
            if (tr) rr <= 0;
        end
        if (!tr) tmo();
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Expected {oe, level} of one output in shutdown
    function automatic logic [1:0] ex(input logic [1:0] l,
        input logic p, n, late);
        case (l)
            cwgsl_pkg::LVL_HIGH: return 2'b11;
            cwgsl_pkg::LVL_LOW: return 2'b10;
            cwgsl_pkg::LVL_TRI: return 2'b00;
            default: return {1'b1, late ? p : n};
        endcase
    endfunction
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic [1:0] r, lk;
        logic [31:0] d;
        logic ok, s, na, nb;
        repeat (12) @(posedge clk);
        rst <= 0;
        axr(cwgsl_pkg::ADDR_CFG, d, r);
        check(d, {24'h0, cwgsl_pkg::CFG_RESET});
        axw(cwgsl_pkg::ADDR_CFG, 32'h0000_00FF, r);
        check(r, cwgsl_pkg::RESP_OKAY);
        axr(cwgsl_pkg::ADDR_CFG, d, r);
        check(d, 32'h0000_00F7);
        axr(32'h0000_0010, d, r);
        check(r, cwgsl_pkg::RESP_SLVERR);
        check(d, 32'h0000_0000);
        axw(32'h0000_0010, 32'h0000_0000, r);
        check(r, cwgsl_pkg::RESP_SLVERR);
        // Every source code, selected input high then low
        for (int c = 0; c < 8; c++)
            for (int j = 0; j < 2; j++)
            begin
                axw(cwgsl_pkg::ADDR_CFG, c, r);
                ok = c >= 2 && c <= 6;
                @(posedge clk);
                v <= ok ? (5'h01 << (c - 2)) ^ {5{j[0]}} : {5{!j[0]}};
                tick(3);
                s = ok && !j;
                check(oa, s ^ pa);
                check(ob, !s ^ pb);
            end
        // Each level code on A, the opposite code on B at once
        for (int k = 0; k < 4; k++)
        begin
            lk = 2'(k);
            na = (lk == 2'h0) ^ pa;
            nb = (lk != 2'h0) ^ pb;
            axw(cwgsl_pkg::ADDR_CFG, {24'h0, ~lk, lk, 4'h2}, r);
            @(posedge clk);
            v <= {4'h0, lk == 2'h0};
            tick(3);
            check(oa, na);
            @(posedge clk);
            sd <= 1;
            tick(db + 1);
            check({oea, oa}, ex(lk, pa, na, 1'b0));
            check({oeb, ob}, ex(~lk, pb, nb, 1'b0));
            tick(1);
            check({oea, oa}, ex(lk, pa, na, 1'b1));
            check({oeb, ob}, ex(~lk, pb, nb, 1'b1));
            axr(cwgsl_pkg::ADDR_STAT, d, r);
            check(d[cwgsl_pkg::STAT_SD], 1'b1);
            @(posedge clk);
            sd <= 0;
            tick(1);
            check({oea, oa}, {1'b1, na});
            check({oeb, ob}, {1'b1, nb});
            check({pinb, pina}, {nb, na});
        end
        give_verdict();
    end
endmodule // cwg_shutdown_level_and_source_select_tb_top
